// file: shared/gdsp_defs.svh
`ifndef GDSP_DEFS_SVH
`define GDSP_DEFS_SVH
`define GDSP_BYTE_W 8
`define GDSP_NCH 4
`define GDSP_CMD_RESET 8'h00
`define GDSP_FLT_RESET 8'h00
`define GDSP_BIT_GATE 0
`define GDSP_BIT_CLR 3
`define GDSP_BIT_MASK 4
`define GDSP_BIT_WRITE 5
`define GDSP_ADDR_LO 6
`define GDSP_ADDR_HI 7
`define GDSP_FLT_STG 0
`define GDSP_FLT_STB 1
`define GDSP_FLT_OL 2
`define GDSP_FLT_THERM 3
`define GDSP_FLT_PUMP 4
`define GDSP_FLT_SUPPLY 5
`define GDSP_OSC_KHZ 4000
`define GDSP_CLK_KHZ 250000
`define GDSP_OSC_DIV (`GDSP_CLK_KHZ / `GDSP_OSC_KHZ)
`endif

// file: shared/gdsp_pkg.sv
package gdsp_pkg;
  typedef logic [1:0] gdsp_chan_t;
  typedef logic [7:0] gdsp_byte_t;
  typedef enum logic [1:0] {
    GDSP_AWAKE = 2'b00,
    GDSP_ASLEEP = 2'b01
  } gdsp_pwr_e;
endpackage

// file: shared/gdsp_xfer_if.sv
`timescale 1ns/1ps
`default_nettype none
interface gdsp_xfer_if;
  logic [7:0] load_byte;
  logic done_tgl;
  logic [7:0] rx_byte;
  logic start_tgl;
  modport link (input load_byte, output done_tgl, output rx_byte, output start_tgl);
  modport core (output load_byte, input done_tgl, input rx_byte, input start_tgl);
endinterface
`default_nettype wire

// file: core/gdsp_shifter.sv
`timescale 1ns/1ps
`include "gdsp_defs.svh"
`default_nettype none
// runs on the serial clock; the frame is bounded by chip select, which resets it
module gdsp_shifter (
  input wire logic sclk,
  input wire logic chip_select_n,
  input wire logic port_off,
  input wire logic sdi,
  output logic sdo,
  output logic sdo_oe_n,
  gdsp_xfer_if.link x
);
  logic [7:0] sh_reg;
  logic [3:0] cnt_reg;
  logic loaded_reg;
  logic start_reg;
  logic done_reg;
  logic [7:0] rx_reg;
  wire frame_rst = chip_select_n | port_off;
  // load on the first edge, first output bit visible combinationally before it
  wire [7:0] cur = loaded_reg ? sh_reg : x.load_byte;
  assign sdo = cur[`GDSP_BYTE_W-1];
  assign sdo_oe_n = chip_select_n | port_off;
  assign x.start_tgl = start_reg;
  assign x.done_tgl = done_reg;
  assign x.rx_byte = rx_reg;
  // sample rising edge, shift out next bit after it (mode 0)
  always_ff @(posedge sclk or posedge frame_rst) begin
    if (frame_rst) begin
      sh_reg <= `GDSP_CMD_RESET;
      cnt_reg <= 4'h0;
      loaded_reg <= 1'b0;
    end else begin
      sh_reg <= {cur[`GDSP_BYTE_W-2:0], sdi};
      loaded_reg <= 1'b1;
      cnt_reg <= (cnt_reg == 4'h7) ? 4'h0 : cnt_reg + 4'h1;
    end
  end
  // frame-end capture clocked by chip select rising; valid only on whole bytes
  // sleep clears the captured byte; the core ignores the resulting toggle while asleep
  always_ff @(posedge chip_select_n or posedge port_off) begin
    if (port_off) begin
      done_reg <= 1'b0;
      rx_reg <= `GDSP_CMD_RESET;
    end else if (loaded_reg && cnt_reg == 4'h0) begin
      rx_reg <= sh_reg;
      done_reg <= ~done_reg;
    end
  end
  // start-of-frame event tells the core to advance channel polling
  always_ff @(negedge chip_select_n or posedge port_off) begin
    if (port_off) start_reg <= 1'b0;
    else start_reg <= ~start_reg;
  end
endmodule // gdsp_shifter
`default_nettype wire

// file: core/gdsp_driver_port.sv
`timescale 1ns/1ps
`include "gdsp_defs.svh"
`default_nettype none
// How it works
// - fault report starts zero; host pulses reset
// - sleep clears command and fault registers
// - all faults ORed onto fault_flag_oe_n; fault_flag_n held low
// - system flags sticky until read out
// - load faults latched per channel
// - serial gate bits ORed with pins
// - timing from 4 MHz internal tick
// - chip select low loads report byte
// - chip select high copies to command
// - inactive select ignores sdi, sdo released
// - daisy chain: last eight bits latched
// - select high in sleep zeroes command
// - non-multiple of eight discarded
// - D5 zero means gate, mask and clear bits ignored
// - D7:D6 channel, D4:D0 operation
// - no faults gives zero byte
// - load fault: address, stg/stb/ol bits
// - system faults only: address zero
// - one channel plus system flags combined
// - several channels reported ascending
// - discrete pin ORed with D0
// - D3 clears, D4 masks stb/ol channel faults
// - reset pulse clears latched faults
module gdsp_driver_port
  import gdsp_pkg::*;
#(
  parameter int NCH = `GDSP_NCH,
  parameter int SLEEP_TICKS = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic master_reset_n,
  input wire logic chip_select_n,
  input wire logic sdi,
  output logic sdo,
  output logic sdo_oe_n,
  input wire logic [NCH-1:0] discrete_gate_input,
  input wire logic [NCH-1:0] stg_detect,
  input wire logic [NCH-1:0] short_to_battery,
  input wire logic [NCH-1:0] open_load,
  input wire logic thermal_warn,
  input wire logic pump_undervoltage,
  input wire logic regulator_undervoltage,
  input wire logic logic_supply_undervoltage,
  output logic [NCH-1:0] gate_on,
  output logic [NCH-1:0] offstate_mask,
  output logic asleep,
  output logic fault_flag_n,
  output logic fault_flag_oe_n,
  output logic [7:0] channel_command
);
  gdsp_xfer_if xf ();

  // pin synchronisers
  logic [1:0] mr_s_reg;
  logic [1:0] cs_s_reg;
  logic [2:0] st_s_reg;
  logic [2:0] dn_s_reg;
  logic [NCH-1:0] in_s1_reg, in_s2_reg;
  logic [3*NCH+3:0] f_s1_reg, f_s2_reg;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mr_s_reg <= 2'b00;
      cs_s_reg <= 2'b11;
      st_s_reg <= 3'b000;
      dn_s_reg <= 3'b000;
      in_s1_reg <= '0;
      in_s2_reg <= '0;
      f_s1_reg <= '0;
      f_s2_reg <= '0;
    end else begin
      mr_s_reg <= {mr_s_reg[0], master_reset_n};
      cs_s_reg <= {cs_s_reg[0], chip_select_n};
      st_s_reg <= {st_s_reg[1:0], xf.start_tgl};
      dn_s_reg <= {dn_s_reg[1:0], xf.done_tgl};
      in_s1_reg <= discrete_gate_input;
      in_s2_reg <= in_s1_reg;
      f_s1_reg <= {thermal_warn, pump_undervoltage, regulator_undervoltage,
                   logic_supply_undervoltage, open_load, short_to_battery, stg_detect};
      f_s2_reg <= f_s1_reg;
    end
  end
  wire mr_n = mr_s_reg[1];
  wire start_evt = st_s_reg[2] ^ st_s_reg[1];
  wire done_evt = dn_s_reg[2] ^ dn_s_reg[1];
  wire [NCH-1:0] stg_s = f_s2_reg[NCH-1:0];
  wire [NCH-1:0] stb_s = f_s2_reg[2*NCH-1:NCH];
  wire [NCH-1:0] ol_s = f_s2_reg[3*NCH-1:2*NCH];
  wire supply_s = f_s2_reg[3*NCH] | f_s2_reg[3*NCH+1];
  wire pump_s = f_s2_reg[3*NCH+2];
  wire therm_s = f_s2_reg[3*NCH+3];

  // 4 MHz tick paces the sleep timer
  logic [7:0] div_reg;
  wire tick = (div_reg == 8'(`GDSP_OSC_DIV - 1));
  always_ff @(posedge clk or posedge rst) begin
    if (rst) div_reg <= 8'h00;
    else div_reg <= tick ? 8'h00 : div_reg + 8'h01;
  end

  // reset low long enough means sleep; short pulse only clears
  gdsp_pwr_e pwr_reg;
  logic [15:0] slp_reg;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pwr_reg <= GDSP_AWAKE;
      slp_reg <= 16'h0000;
    end else begin
      case (pwr_reg)
        GDSP_AWAKE: begin
          if (mr_n) slp_reg <= 16'h0000;
          else if (tick) slp_reg <= slp_reg + 16'h0001;
          if (!mr_n && slp_reg == 16'(SLEEP_TICKS)) pwr_reg <= GDSP_ASLEEP;
        end
        GDSP_ASLEEP: begin
          slp_reg <= 16'h0000;
          if (mr_n) pwr_reg <= GDSP_AWAKE;
        end
        default: pwr_reg <= GDSP_AWAKE;
      endcase
    end
  end
  wire sleeping = (pwr_reg == GDSP_ASLEEP);
  wire clr_all = !mr_n;
  assign asleep = sleeping;

  // command decode
  logic [7:0] cmd_reg;
  wire [7:0] rx = xf.rx_byte;
  wire cmd_ok = done_evt && rx[`GDSP_BIT_WRITE] && !sleeping;
  wire [1:0] cmd_ch = rx[`GDSP_ADDR_HI:`GDSP_ADDR_LO];
  always_ff @(posedge clk or posedge rst) begin
    if (rst) cmd_reg <= `GDSP_CMD_RESET;
    else if (clr_all || sleeping) cmd_reg <= `GDSP_CMD_RESET;
    else if (done_evt) cmd_reg <= rx;
  end
  assign channel_command = cmd_reg;

  // per-channel latched load faults, gate and mask bits
  logic [NCH-1:0] stg_reg, stb_reg, ol_reg, gate_reg, mask_reg;
  genvar g;
  for (g = 0; g < NCH; g++) begin : g_ch
    wire sel = cmd_ok && (cmd_ch == 2'(g));
    wire clr = clr_all || sleeping || (sel && rx[`GDSP_BIT_CLR]);
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        stg_reg[g] <= 1'b0;
        stb_reg[g] <= 1'b0;
        ol_reg[g] <= 1'b0;
        gate_reg[g] <= 1'b0;
        mask_reg[g] <= 1'b0;
      end else begin
        // new detection wins over a clear in the same cycle
        stg_reg[g] <= stg_s[g] | (stg_reg[g] & ~clr);
        stb_reg[g] <= (stb_s[g] & ~mask_reg[g]) | (stb_reg[g] & ~clr);
        ol_reg[g] <= (ol_s[g] & ~mask_reg[g]) | (ol_reg[g] & ~clr);
        if (clr_all || sleeping) begin
          gate_reg[g] <= 1'b0;
          mask_reg[g] <= 1'b0;
        end else if (sel) begin
          gate_reg[g] <= rx[`GDSP_BIT_GATE];
          mask_reg[g] <= rx[`GDSP_BIT_MASK];
        end
      end
    end
  end
  assign gate_on = (gate_reg | in_s2_reg) & ~{NCH{sleeping}};
  assign offstate_mask = mask_reg;

  // sticky system flags, cleared once shipped in a frame
  logic [2:0] sys_reg;
  wire [2:0] sys_now = {supply_s, pump_s, therm_s};
  always_ff @(posedge clk or posedge rst) begin
    if (rst) sys_reg <= 3'b000;
    else if (clr_all || sleeping) sys_reg <= 3'b000;
    else if (start_evt) sys_reg <= sys_now;
    else sys_reg <= sys_reg | sys_now;
  end

  // pick next faulty channel above the last reported one
  logic [1:0] last_reg;
  wire [NCH-1:0] lf = stg_reg | stb_reg | ol_reg;
  function automatic logic [2:0] next_ch(input logic [NCH-1:0] f, input logic [1:0] after);
    logic [2:0] r;
    int i;
    r = 3'b000;
    for (i = NCH - 1; i >= 0; i--) begin
      if (f[i]) r = {1'b1, 2'(i)};
    end
    for (i = NCH - 1; i >= 0; i--) begin
      if (f[i] && 2'(i) > after) r = {1'b1, 2'(i)};
    end
    return r;
  endfunction
  wire [2:0] pick = next_ch(lf, last_reg);
  logic [7:0] rep_reg;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rep_reg <= `GDSP_FLT_RESET;
      last_reg <= 2'b11;
    end else if (clr_all || sleeping) begin
      rep_reg <= `GDSP_FLT_RESET;
      last_reg <= 2'b11;
    end else begin
      // stable while a frame is open; it reloads every clock while synchronised select is high
      if (cs_s_reg[1]) begin
        rep_reg <= pick[2] ? {pick[1:0], sys_reg, ol_reg[pick[1:0]],
                              stb_reg[pick[1:0]], stg_reg[pick[1:0]]}
                           : {2'b00, sys_reg, 3'b000};
      end
      if (start_evt && pick[2]) last_reg <= pick[1:0];
    end
  end
  assign xf.load_byte = rep_reg;

  assign fault_flag_n = 1'b0;
  assign fault_flag_oe_n = ~(|lf | |sys_now | |sys_reg);

  gdsp_shifter u_sh (
    .sclk(sclk),
    .chip_select_n(chip_select_n),
    .port_off(sleeping),
    .sdi(sdi),
    .sdo(sdo),
    .sdo_oe_n(sdo_oe_n),
    .x(xf)
  );
endmodule // gdsp_driver_port
`default_nettype wire

// file: tb/gdsp_properties.sv
`timescale 1ns/1ps
`default_nettype none
module gdsp_checker #(parameter int NCH = 4) (
  input wire logic clk,
  input wire logic rst,
  input wire logic master_reset_n,
  input wire logic chip_select_n,
  input wire logic sdo_oe_n,
  input wire logic thermal_warn,
  input wire logic [NCH-1:0] discrete_gate_input,
  input wire logic [NCH-1:0] gate_on,
  input wire logic asleep,
  input wire logic fault_flag_n,
  input wire logic fault_flag_oe_n,
  input wire logic [7:0] channel_command
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  chk_sdo_idle: assert property (chip_select_n |-> sdo_oe_n)
    else $error("sdo driven while deselected");
  chk_sdo_drive: assert property (!chip_select_n && $past(!chip_select_n) && !asleep |-> !sdo_oe_n)
    else $error("sdo not driven in frame");
  chk_flag_low: assert property (fault_flag_n == 1'b0)
    else $error("fault pin level not low");
  chk_flag_sys: assert property (thermal_warn && !asleep |-> ##[1:6] !fault_flag_oe_n)
    else $error("system fault not flagged");
  chk_gate_pin: assert property ($rose(discrete_gate_input[2]) && !asleep |-> ##[1:6] gate_on[2])
    else $error("pin did not switch gate");
  chk_sleep_clear: assert property (asleep ##1 asleep |-> channel_command == 8'h00 && gate_on == '0)
    else $error("state kept in sleep");
  chk_cmd_hold: assert property (!chip_select_n && $past(!chip_select_n, 5) && master_reset_n
    && $past(master_reset_n) |-> $stable(channel_command))
    else $error("command changed mid frame");
  chk_reset_clear: assert property (!master_reset_n [*8] |-> channel_command == 8'h00)
    else $error("reset pulse left command");
  cover property ($rose(asleep));
  cover property ($rose(chip_select_n));
  cover property ($fell(fault_flag_oe_n));
endmodule // gdsp_checker
bind gdsp_driver_port gdsp_checker #(.NCH(NCH)) gdsp_checker_inst (.clk(clk), .rst(rst),
  .master_reset_n(master_reset_n), .chip_select_n(chip_select_n), .sdo_oe_n(sdo_oe_n),
  .thermal_warn(thermal_warn), .discrete_gate_input(discrete_gate_input), .gate_on(gate_on),
  .asleep(asleep), .fault_flag_n(fault_flag_n), .fault_flag_oe_n(fault_flag_oe_n),
  .channel_command(channel_command));
`default_nettype wire

// file: tb/gdsp_host.sv
`timescale 1ns/1ps
`default_nettype none
module gdsp_host (
  output logic sclk,
  output logic chip_select_n,
  output logic sdi,
  input wire logic sdo
);
  initial begin
    sclk = 1'b0;
    chip_select_n = 1'b1;
    sdi = 1'b1;
  end
  // sclk parked low between frames; odd start offset keeps it off the system clock
  task automatic frame(input int n, input logic [15:0] tx, output logic [15:0] rx);
    #1.3 chip_select_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      sdi = tx[i];
      #32 rx = {rx[14:0], sdo};
      sclk = 1'b1;
      #32 sclk = 1'b0;
    end
    #32 chip_select_n = 1'b1;
    sdi = ~sdi;
    #64;
  endtask
endmodule // gdsp_host
`default_nettype wire

// file: tb/gdsp_driver_port_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin errors++; $display("unexpected %0t got %h want %h", $time, a, b); end end
module gdsp_driver_port_tb;
  import gdsp_pkg::*;
  logic clk, rst, sclk, master_reset_n, chip_select_n, sdi, sdo, sdo_oe_n, asleep;
  logic thermal_warn, pump_undervoltage, regulator_undervoltage, fault_flag_n, fault_flag_oe_n;
  logic logic_supply_undervoltage;
  logic [3:0] discrete_gate_input, stg_detect, short_to_battery, open_load, gate_on, offstate_mask;
  logic [7:0] channel_command;
  logic [15:0] rx;
  int errors = 0;
  int compares = 0;
  int cycles = 0;
  gdsp_driver_port #(.SLEEP_TICKS(4)) gdsp_driver_port_inst (
    .clk(clk),
    .rst(rst),
    .sclk(sclk),
    .master_reset_n(master_reset_n),
    .chip_select_n(chip_select_n),
    .sdi(sdi),
    .sdo(sdo),
    .sdo_oe_n(sdo_oe_n),
    .discrete_gate_input(discrete_gate_input),
    .stg_detect(stg_detect),
    .short_to_battery(short_to_battery),
    .open_load(open_load),
    .thermal_warn(thermal_warn),
    .pump_undervoltage(pump_undervoltage),
    .regulator_undervoltage(regulator_undervoltage),
    .logic_supply_undervoltage(logic_supply_undervoltage),
    .gate_on(gate_on),
    .offstate_mask(offstate_mask),
    .asleep(asleep),
    .fault_flag_n(fault_flag_n),
    .fault_flag_oe_n(fault_flag_oe_n),
    .channel_command(channel_command)
  );
  gdsp_host gdsp_host_inst (.sclk(sclk), .chip_select_n(chip_select_n), .sdi(sdi), .sdo(sdo));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic complete_run;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      complete_run();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic xf(input int n, input logic [15:0] tx);
    gdsp_host_inst.frame(n, tx, rx);
    tick(2);
  endtask
  // short low clears latches; stays under the sleep time
  task automatic pulse_reset;
    master_reset_n <= 1'b0;
    tick(80);
    master_reset_n <= 1'b1;
    tick(20);
  endtask
  task automatic t_write;
    xf(8, 16'h0061);
    `CHK(rx[7:0], 8'h00)
    `CHK(gate_on, 4'b0010)
    xf(8, 16'h0001);
    `CHK(channel_command, 8'h01)
    `CHK(gate_on, 4'b0010)
    discrete_gate_input <= 4'b0100;
    tick(8);
    `CHK(gate_on, 4'b0110)
    xf(7, 16'h0021);
    `CHK(channel_command, 8'h01)
    xf(16, 16'h0821);
    `CHK(rx, 16'h0008)
    `CHK(gate_on, 4'b0111)
    xf(8, 16'h00B0);
    `CHK(offstate_mask, 4'b0100)
    `CHK(gate_on, 4'b0111)
    `CHK(sdo_oe_n, 1'b1)
    discrete_gate_input <= 4'b0000;
    $display("write test done");
  endtask
  task automatic t_sleep;
    master_reset_n <= 1'b0;
    tick(400);
    `CHK(asleep, 1'b1)
    `CHK({gate_on, channel_command}, 12'h000)
    master_reset_n <= 1'b1;
    tick(50);
    pulse_reset();
    `CHK(asleep, 1'b0)
    $display("sleep test done");
  endtask
  task automatic t_load;
    {open_load, short_to_battery, stg_detect} <= 12'h248;
    pump_undervoltage <= 1'b1;
    tick(100);
    {open_load, short_to_battery, stg_detect} <= 12'h000;
    xf(8, 16'h0000);
    `CHK(rx[7:0], 8'h54)
    xf(8, 16'h0000);
    `CHK(rx[7:0], 8'h92)
    xf(8, 16'h0000);
    `CHK(rx[7:0], 8'hD1)
    pump_undervoltage <= 1'b0;
    tick(100);
    xf(8, 16'h0000);
    `CHK(rx[7:0], 8'h54)
    xf(8, 16'h0068);
    `CHK(rx[7:0], 8'h82)
    xf(8, 16'h0000);
    `CHK(rx[7:0], 8'hC1)
    xf(8, 16'h0000);
    `CHK(rx[7:0], 8'h82)
    `CHK(fault_flag_oe_n, 1'b0)
    `CHK(fault_flag_n, 1'b0)
    pulse_reset();
    xf(8, 16'h0000);
    `CHK({fault_flag_oe_n, rx[7:0]}, 9'h100)
    $display("load test done");
  endtask
  task automatic t_sys;
    {thermal_warn, regulator_undervoltage} <= 2'b11;
    tick(100);
    {thermal_warn, regulator_undervoltage} <= 2'b00;
    tick(100);
    xf(8, 16'h0000);
    `CHK(rx[7:0], 8'h28)
    xf(8, 16'h0000);
    `CHK(rx[7:0], 8'h00)
    $display("system test done");
  endtask
  initial begin
    rst = 1'b1;
    {master_reset_n, thermal_warn, pump_undervoltage, regulator_undervoltage} = 4'h8;
    logic_supply_undervoltage = 1'b0;
    {discrete_gate_input, stg_detect, short_to_battery, open_load} = 16'h0000;
    tick(5);
    rst <= 1'b0;
    tick(10);
    pulse_reset();
    t_write();
    t_sleep();
    t_load();
    t_sys();
    complete_run();
  end
endmodule // gdsp_driver_port_tb
`default_nettype wire
